/* File: hw/sccp_map.vh */
// Constants for the star camera control and pixel prefilter block.
// Assumes inclusion by bare name from the design file under hw/.
//
// Contract
// - Every second 1 Hz tick, send a fixed 32-byte command sequence.
// - Store each reply byte into housekeeping memory on arrival, in sequence order.
// - First sequence byte is always the readout start command.
// - Readout start uses long or short code per stored integration setting.
// - Other bytes are plain requests, except one heater command byte.
// - Lens reading below setpoint switches on the selected heater.
// - Setpoint command loads lens setpoint and main/alternate heater choice.
// - Prefilter configuration is loaded just before each readout start command.
// - Region mode forwards pixels in four 5x5 windows or diagnostic regions.
// - Region mode used in track and diagnostic, intermittently in search.
// - Threshold mode forwards pixels above threshold plus diagnostic regions.
// - Threshold mode only selectable while in search mode.
// - No bad column or bad pixel rejection in the prefilter.
// - Image data is popped from the FIFO on each data-ready event.
// - Search mode enters track mode once suitable stars are found.
// - Track mode returns to search mode when stars are lost.
// - Diagnostic mode steps a 3x12 patch each frame across the CCD.
// - Data-ready pulses whenever a pixel is written into the FIFO.
`ifndef SCCP_MAP_VH
`define SCCP_MAP_VH
`define SCCP_SEQ_LAST      5'h1F
`define SCCP_HEATER_IDX    5'h10
`define SCCP_LENS_IDX      5'h0F
`define SCCP_CMD_RD_LONG   8'h81
`define SCCP_CMD_RD_SHORT  8'h82
`define SCCP_CMD_HEATER    8'hC0
`define SCCP_CMD_REQ_BASE  8'h20
`define SCCP_MODE_SEARCH   2'h0
`define SCCP_MODE_TRACK    2'h1
`define SCCP_MODE_DIAG     2'h2
`define SCCP_DIAG_ROWS     10'h008
`define SCCP_DIAG_END      10'h3F8
`define SCCP_ROI_SIZE      10'h005
`define SCCP_PATCH_W       10'h00C
`define SCCP_PATCH_H       10'h003
`define SCCP_CCD_LAST      10'h3FF
`define SCCP_FIFO_LAST     4'hF
`define SCCP_FIFO_FULL     5'h10
`endif

/* File: hw/sccp_top.v */
// Star camera command sequencer, lens heater loop, mode tracker and pixel prefilter.
// Assumes pixel stream and config ports are on sys_clk; tick and camera reply are pins.
`timescale 1ns/1ps
`include "sccp_map.vh"

module sccp_top (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        tick_1hz,
   output reg  [7:0]  cam_cmd_data_q,
   output reg         cam_cmd_stb_q,
   input  wire [7:0]  cam_reply_data,
   input  wire        cam_reply_stb,
   input  wire        integration_time_select_cmd,
   input  wire        int_long,
   input  wire        lens_setpoint_cmd,
   input  wire [7:0]  lens_setpoint,
   input  wire        heater_alt,
   input  wire [4:0]  hk_rd_addr,
   output reg  [7:0]  hk_rd_data_q,
   output reg  [7:0]  lens_temp_q,
   output reg  [1:0]  heater_on_q,
   output reg         seq_busy_q,
   input  wire        stars_found,
   input  wire        stars_lost,
   input  wire        diag_enter,
   input  wire        diag_exit,
   output reg  [1:0]  mode_q,
   input  wire        search_roi_sel,
   input  wire [11:0] threshold,
   input  wire [39:0] roi_x,
   input  wire [39:0] roi_y,
   output reg         roi_mode_q,
   input  wire        frame_start,
   input  wire        pix_valid,
   input  wire [9:0]  pix_x,
   input  wire [9:0]  pix_y,
   input  wire [11:0] pix_amp,
   output reg         data_ready_q,
   input  wire        fifo_rd,
   output reg  [31:0] fifo_dout_q,
   output reg         fifo_empty_q
);

   localparam ST_IDLE = 2'h0;
   localparam ST_CFG  = 2'h1;
   localparam ST_SEND = 2'h2;
   localparam ST_WAIT = 2'h3;

   // Corner-anchored box membership, shared by windows and patch
   function in_box;
      input [9:0] px;
      input [9:0] py;
      input [9:0] x0;
      input [9:0] y0;
      input [9:0] w;
      input [9:0] h;
      begin
         in_box = (px >= x0) && ({1'b0, px} < ({1'b0, x0} + {1'b0, w})) &&
                  (py >= y0) && ({1'b0, py} < ({1'b0, y0} + {1'b0, h}));
      end
   endfunction

   // Diagnostic mode decode, shared by patch stepping and patch match
   function is_diag;
      input [1:0] m;
      begin
         is_diag = (m == `SCCP_MODE_DIAG);
      end
   endfunction

   reg  [2:0]  tick_sync_q;
   reg  [2:0]  rstb_sync_q;
   reg  [7:0]  rdat_s1_q;
   reg  [7:0]  rdat_s2_q;
   reg         tick_phase_q;
   reg  [1:0]  state_q;
   reg  [4:0]  idx_q;
   reg         int_long_q;
   reg  [7:0]  setpoint_q;
   reg         heater_alt_q;
   reg  [7:0]  hk_mem [0:31];
   reg  [11:0] thr_q;
   reg  [39:0] roi_x_q;
   reg  [39:0] roi_y_q;
   reg  [9:0]  patch_x_q;
   reg  [9:0]  patch_y_q;
   reg  [31:0] fifo_mem [0:15];
   reg  [3:0]  wr_ptr_q;
   reg  [3:0]  rd_ptr_q;
   reg  [4:0]  count_q;
   reg  [7:0]  cmd_byte;
   reg  [4:0]  count_d;
   wire        tick_rise;
   wire        reply_rise;
   wire [3:0]  roi_hit;
   wire        diag_hit;
   wire        patch_hit;
   wire        sel_hit;
   wire        accept;
   wire        pop;
   wire [1:0]  heater_req;

   // Pin synchronisers; stage 1 feeds stage 2 only
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_sync_q <= 3'h0;
         rstb_sync_q <= 3'h0;
         rdat_s1_q   <= 8'h00;
         rdat_s2_q   <= 8'h00;
      end else begin
         tick_sync_q <= {tick_sync_q[1:0], tick_1hz};
         rstb_sync_q <= {rstb_sync_q[1:0], cam_reply_stb};
         rdat_s1_q   <= cam_reply_data;
         rdat_s2_q   <= rdat_s1_q;
      end
   end

   assign tick_rise  = tick_sync_q[1] & ~tick_sync_q[2];
   assign reply_rise = rstb_sync_q[1] & ~rstb_sync_q[2];

   // Config commands: integration time, setpoint and heater choice
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         int_long_q   <= 1'b0;
         setpoint_q   <= 8'h00;
         heater_alt_q <= 1'b0;
      end else begin
         if (integration_time_select_cmd)
            int_long_q <= int_long;
         if (lens_setpoint_cmd) begin
            setpoint_q   <= lens_setpoint;
            heater_alt_q <= heater_alt;
         end
      end
   end

   // Heater request from latest lens reading
   assign heater_req = (lens_temp_q < setpoint_q) ?
                       (heater_alt_q ? 2'b10 : 2'b01) :
                       2'b00;

   // Command byte for the current sequence slot
   always @* begin
      if (idx_q == 5'h00)
         cmd_byte = int_long_q ? `SCCP_CMD_RD_LONG : `SCCP_CMD_RD_SHORT;
      else if (idx_q == `SCCP_HEATER_IDX)
         cmd_byte = `SCCP_CMD_HEATER | {6'h00, heater_req};
      else
         cmd_byte = `SCCP_CMD_REQ_BASE + {3'h0, idx_q};
   end

   // Tick parity: a sequence starts on every second synchronised tick
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         tick_phase_q <= 1'b0;
      else if (tick_rise)
         tick_phase_q <= ~tick_phase_q;
   end

   // Sequencer: config load, then 32 byte send/reply exchanges
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q        <= ST_IDLE;
         idx_q          <= 5'h00;
         cam_cmd_data_q <= 8'h00;
         cam_cmd_stb_q  <= 1'b0;
         seq_busy_q     <= 1'b0;
      end else begin
         cam_cmd_stb_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               seq_busy_q <= 1'b0;
               if (tick_rise && tick_phase_q) begin
                  state_q    <= ST_CFG;
                  seq_busy_q <= 1'b1;
               end
            end
            ST_CFG: begin
               idx_q   <= 5'h00;
               state_q <= ST_SEND;
            end
            ST_SEND: begin
               cam_cmd_data_q <= cmd_byte;
               cam_cmd_stb_q  <= 1'b1;
               state_q        <= ST_WAIT;
            end
            ST_WAIT: begin
               // One reply per command byte paces the sequence; a lost reply stalls it
               if (reply_rise) begin
                  if (idx_q == `SCCP_SEQ_LAST) begin
                     state_q <= ST_IDLE;
                  end else begin
                     idx_q   <= idx_q + 5'h01;
                     state_q <= ST_SEND;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Prefilter setup, loaded in the cycle before readout start goes out
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         thr_q      <= 12'h000;
         roi_x_q    <= 40'h00_0000_0000;
         roi_y_q    <= 40'h00_0000_0000;
         roi_mode_q <= 1'b1;
      end else if (state_q == ST_CFG) begin
         thr_q      <= threshold;
         roi_x_q    <= roi_x;
         roi_y_q    <= roi_y;
         roi_mode_q <= (mode_q != `SCCP_MODE_SEARCH) | search_roi_sel;
      end
   end

   // Lens reading and applied heater state, taken from the exchange
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lens_temp_q <= 8'h00;
         heater_on_q <= 2'b00;
      end else begin
         if (state_q == ST_SEND && idx_q == `SCCP_HEATER_IDX)
            heater_on_q <= heater_req;
         if (state_q == ST_WAIT && reply_rise && idx_q == `SCCP_LENS_IDX)
            lens_temp_q <= rdat_s2_q;
      end
   end

   // Housekeeping store, slot equals command index
   always @(posedge sys_clk) begin
      if (state_q == ST_WAIT && reply_rise)
         hk_mem[idx_q] <= rdat_s2_q;
   end

   // Housekeeping read port
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         hk_rd_data_q <= 8'h00;
      else
         hk_rd_data_q <= hk_mem[hk_rd_addr];
   end

   // Operating mode tracker
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_q <= `SCCP_MODE_SEARCH;
      end else begin
         case (mode_q)
            `SCCP_MODE_SEARCH: begin
               if (diag_enter)
                  mode_q <= `SCCP_MODE_DIAG;
               else if (stars_found)
                  mode_q <= `SCCP_MODE_TRACK;
            end
            `SCCP_MODE_TRACK: begin
               if (diag_enter)
                  mode_q <= `SCCP_MODE_DIAG;
               else if (stars_lost)
                  mode_q <= `SCCP_MODE_SEARCH;
            end
            `SCCP_MODE_DIAG: begin
               if (diag_exit)
                  mode_q <= `SCCP_MODE_SEARCH;
            end
            default: mode_q <= `SCCP_MODE_SEARCH;
         endcase
      end
   end

   // Diagnostic patch steps one place per frame, row-major wrap
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         patch_x_q <= 10'h000;
         patch_y_q <= 10'h000;
      end else if (frame_start && is_diag(mode_q)) begin
         // Last place may overhang the edge so the final columns and rows are swept
         if ({1'b0, patch_x_q} + {1'b0, `SCCP_PATCH_W} > {1'b0, `SCCP_CCD_LAST}) begin
            patch_x_q <= 10'h000;
            if ({1'b0, patch_y_q} + {1'b0, `SCCP_PATCH_H} > {1'b0, `SCCP_CCD_LAST})
               patch_y_q <= 10'h000;
            else
               patch_y_q <= patch_y_q + `SCCP_PATCH_H;
         end else begin
            patch_x_q <= patch_x_q + `SCCP_PATCH_W;
         end
      end
   end

   // Four addressable 5x5 windows
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_roi
         assign roi_hit[gi] = in_box(pix_x, pix_y, roi_x_q[gi*10 +: 10],
                                     roi_y_q[gi*10 +: 10],
                                     `SCCP_ROI_SIZE, `SCCP_ROI_SIZE);
      end
   endgenerate

   assign patch_hit = is_diag(mode_q) &&
                      in_box(pix_x, pix_y, patch_x_q, patch_y_q,
                             `SCCP_PATCH_W, `SCCP_PATCH_H);
   // Fixed diagnostic regions at image start and end
   assign diag_hit  = (pix_y < `SCCP_DIAG_ROWS) || (pix_y >= `SCCP_DIAG_END);
   // No bad column or pixel screening here; downstream handles it
   assign sel_hit   = roi_mode_q ? ((|roi_hit) | patch_hit)
                                 : (pix_amp > thr_q);
   assign accept    = pix_valid && (diag_hit || sel_hit) && (count_q != `SCCP_FIFO_FULL);
   assign pop       = fifo_rd && (count_q != 5'h00);

   // FIFO occupancy
   always @* begin
      count_d = count_q;
      if (accept && !pop)
         count_d = count_q + 5'h01;
      else if (pop && !accept)
         count_d = count_q - 5'h01;
   end

   // Pixel FIFO storage
   always @(posedge sys_clk) begin
      if (accept)
         fifo_mem[wr_ptr_q] <= {pix_x, pix_y, pix_amp};
   end

   // FIFO pointers, read data and data-ready event
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q     <= 4'h0;
         rd_ptr_q     <= 4'h0;
         count_q      <= 5'h00;
         fifo_empty_q <= 1'b1;
         fifo_dout_q  <= 32'h0000_0000;
         data_ready_q <= 1'b0;
      end else begin
         count_q      <= count_d;
         fifo_empty_q <= (count_d == 5'h00);
         data_ready_q <= accept;
         if (accept)
            wr_ptr_q <= wr_ptr_q + 4'h1;
         if (pop) begin
            fifo_dout_q <= fifo_mem[rd_ptr_q];
            rd_ptr_q    <= rd_ptr_q + 4'h1;
         end
      end
   end

endmodule // sccp_top

/* File: verification/sccp_checker.sv */
// Concurrent checks on the star camera block ports.
// Assumes one clock sys_clk and async high reset rst.
`timescale 1ns/1ps
module sccp_checker (
   input logic        sys_clk,
   input logic        rst,
   input logic        cam_cmd_stb_q,
   input logic [7:0]  cam_cmd_data_q,
   input logic        seq_busy_q,
   input logic        pix_valid,
   input logic [9:0]  pix_x,
   input logic [9:0]  pix_y,
   input logic [11:0] pix_amp,
   input logic [11:0] threshold,
   input logic [39:0] roi_x,
   input logic [39:0] roi_y,
   input logic        roi_mode_q,
   input logic        data_ready_q,
   input logic        fifo_empty_q,
   input logic [1:0]  mode_q,
   input logic        stars_found,
   input logic        stars_lost,
   input logic        diag_enter
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Camera command framing
   a_cmd_strobe_single: assert property (cam_cmd_stb_q |=> !cam_cmd_stb_q)
      else $error("command strobe longer than one cycle");
   a_cmd_in_seq: assert property (cam_cmd_stb_q |-> seq_busy_q)
      else $error("command sent outside a sequence");
   a_first_readout: assert property ($rose(seq_busy_q) |-> ##[1:4] (cam_cmd_stb_q &&
      (cam_cmd_data_q == 8'h81 || cam_cmd_data_q == 8'h82)))
      else $error("sequence did not open with readout start");
   // Prefilter acceptance
   a_ready_cause: assert property (data_ready_q |-> $past(pix_valid) && !fifo_empty_q)
      else $error("data ready without a stored pixel");
   a_diag_accept: assert property (pix_valid && fifo_empty_q &&
      (pix_y < 10'h008 || pix_y >= 10'h3F8) |=> data_ready_q)
      else $error("diagnostic region pixel dropped");
   a_thresh_drop: assert property (pix_valid && !roi_mode_q && pix_amp <= threshold &&
      pix_y >= 10'h008 && pix_y < 10'h3F8 |=> !data_ready_q)
      else $error("pixel at or below threshold stored");
   a_roi_accept: assert property (pix_valid && roi_mode_q && fifo_empty_q &&
      pix_x >= roi_x[9:0] && pix_x < roi_x[9:0] + 10'h005 &&
      pix_y >= roi_y[9:0] && pix_y < roi_y[9:0] + 10'h005 |=> data_ready_q)
      else $error("window pixel dropped");
   // Operating mode
   a_thresh_search: assert property ($fell(roi_mode_q) |-> mode_q == 2'h0)
      else $error("threshold filter outside search");
   a_region_forced: assert property ($rose(seq_busy_q) && mode_q != 2'h0 |=> roi_mode_q)
      else $error("region filter not forced outside search");
   a_search_track: assert property (mode_q == 2'h0 && stars_found && !diag_enter
      |=> mode_q == 2'h1)
      else $error("no entry to track");
   a_track_search: assert property (mode_q == 2'h1 && stars_lost && !diag_enter
      |=> mode_q == 2'h0)
      else $error("no return to search");
endmodule // sccp_checker

bind sccp_top sccp_checker sccp_checker_i (.sys_clk, .rst, .cam_cmd_stb_q, .cam_cmd_data_q,
   .seq_busy_q, .pix_valid, .pix_x, .pix_y, .pix_amp, .threshold, .roi_x, .roi_y, .roi_mode_q,
   .data_ready_q, .fifo_empty_q, .mode_q, .stars_found, .stars_lost, .diag_enter);

/* File: verification/sccp_camera_model.sv */
// Camera model: one reply byte per command byte.
// Assumes strobe and data from the block on sys_clk.
`timescale 1ns/1ps
module sccp_camera_model (
   input  wire       sys_clk,
   input  wire [7:0] cam_cmd_data_q,
   input  wire       cam_cmd_stb_q,
   input  wire [7:0] lens_reading,
   input  wire       slow,
   output reg  [7:0] rdata,
   output reg        rstb
);
   integer idx = 0;
   initial rdata = 8'h00;
   initial rstb = 1'b0;
   // Reply with data stable around the strobe, then scramble it
   always @(posedge sys_clk) begin
      if (cam_cmd_stb_q === 1'b1) begin
         idx = (cam_cmd_data_q == 8'h81 || cam_cmd_data_q == 8'h82) ? 0 : idx + 1;
         repeat (slow ? 20 : 2) @(posedge sys_clk);
         #1 rdata = (idx == 15) ? lens_reading : 8'h40 + idx;
         repeat (3) @(posedge sys_clk);
         #1 rstb = 1'b1;
         repeat (3) @(posedge sys_clk);
         #1 rstb = 1'b0;
         rdata = ~rdata; // Released; back in time for the next strobe
      end
   end
endmodule // sccp_camera_model

/* File: verification/testbench.sv */
// Self-checking bench for the star camera block.
// Assumes a 40 MHz clock and the camera model on the link.
`timescale 1ns/1ps
module testbench;
   reg sys_clk = 0, rst = 1, tick_1hz = 0, slow = 0, int_long = 0, heater_alt = 0;
   reg integration_time_select_cmd = 0, lens_setpoint_cmd = 0, search_roi_sel = 0;
   reg stars_found = 0, stars_lost = 0, diag_enter = 0, diag_exit = 0, frame_start = 0;
   reg pix_valid = 0, fifo_rd = 0;
   reg [7:0] lens_setpoint = 0, lens = 8'h70, cmds [0:31];
   reg [4:0] hk_rd_addr = 0;
   reg [11:0] threshold = 12'h0100, pix_amp = 0;
   reg [39:0] roi_x = {10'h300, 10'h3F0, 10'h3F0, 10'h064};
   reg [39:0] roi_y = {10'h300, 10'h3F0, 10'h3F0, 10'h0C8};
   reg [9:0] pix_x = 0, pix_y = 0;
   wire [7:0] cam_cmd_data_q, cam_reply_data, hk_rd_data_q, lens_temp_q;
   wire [1:0] heater_on_q, mode_q;
   wire [31:0] fifo_dout_q;
   wire cam_cmd_stb_q, cam_reply_stb, seq_busy_q, roi_mode_q, data_ready_q, fifo_empty_q;
   integer mismatches = 0, checks = 0, ncmd = 0;
   always #12.5 sys_clk = ~sys_clk;
   sccp_top sccp_top_i (.sys_clk, .rst, .tick_1hz, .cam_cmd_data_q, .cam_cmd_stb_q,
      .cam_reply_data, .cam_reply_stb, .integration_time_select_cmd, .int_long,
      .lens_setpoint_cmd, .lens_setpoint, .heater_alt, .hk_rd_addr, .hk_rd_data_q,
      .lens_temp_q, .heater_on_q, .seq_busy_q, .stars_found, .stars_lost, .diag_enter,
      .diag_exit, .mode_q, .search_roi_sel, .threshold, .roi_x, .roi_y, .roi_mode_q,
      .frame_start, .pix_valid, .pix_x, .pix_y, .pix_amp, .data_ready_q, .fifo_rd,
      .fifo_dout_q, .fifo_empty_q);
   sccp_camera_model sccp_camera_model_i (.sys_clk, .cam_cmd_data_q, .cam_cmd_stb_q,
      .lens_reading(lens), .slow, .rdata(cam_reply_data), .rstb(cam_reply_stb));
   // Command byte monitor
   always @(posedge sys_clk) if (cam_cmd_stb_q === 1'b1) begin
      if (ncmd < 32) cmds[ncmd] <= cam_cmd_data_q;
      ncmd <= ncmd + 1;
   end
   task step(input integer n); begin repeat (n) @(posedge sys_clk); #1; end endtask
   task chk(input [31:0] got, input [31:0] exp); begin
      checks = checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   end endtask
   task print_verdict; begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   end endtask
   // Both config commands in one cycle
   task cfg(input il, input [7:0] sp, input alt); begin
      int_long = il; lens_setpoint = sp; heater_alt = alt;
      integration_time_select_cmd = 1; lens_setpoint_cmd = 1; step(1);
      integration_time_select_cmd = 0; lens_setpoint_cmd = 0;
   end endtask
   // Two ticks, whole sequence, then housekeeping readback
   task run_seq(input [7:0] b0, input [7:0] b16, input [1:0] heat);
      integer i;
      begin
         ncmd = 0;
         for (i = 0; i < 2; i = i + 1) begin
            tick_1hz = 1; step(4); tick_1hz = 0; step(4);
            if (i == 0) chk(seq_busy_q, 0);
         end
         i = 0;
         while (seq_busy_q !== 1'b0 && i < 3000) begin step(1); i = i + 1; end
         step(2);
         chk(ncmd, 32);
         chk(cmds[0], b0);
         chk(cmds[16], b16);
         chk(heater_on_q, heat);
         for (i = 1; i < 32; i = i + 1) if (i != 16) chk(cmds[i], 8'h20 + i);
         for (i = 0; i < 32; i = i + 1) begin
            hk_rd_addr = i; step(1);
            chk(hk_rd_data_q, (i == 15) ? lens : 8'h40 + i);
         end
         chk(lens_temp_q, lens);
         $display("sequence done");
      end
   endtask
   // One pixel; pop and compare if it should be kept
   task px(input [9:0] x, input [9:0] y, input [11:0] a, input acc); begin
      pix_x = x; pix_y = y; pix_amp = a; pix_valid = 1; step(1); pix_valid = 0;
      chk(data_ready_q, acc);
      if (acc) begin fifo_rd = 1; step(1); fifo_rd = 0; chk(fifo_dout_q, {x, y, a}); end
      chk(fifo_empty_q, 1);
      step(1);
   end endtask
   // Mode change by one pulse
   task pulse_mode(input [3:0] p, input [1:0] m); begin
      {stars_found, stars_lost, diag_enter, diag_exit} = p; step(1);
      {stars_found, stars_lost, diag_enter, diag_exit} = 0; chk(mode_q, m);
      step(1);
   end endtask
   // Watchdog: a few sequences need about 2000 cycles
   initial begin #400_000; mismatches = mismatches + 1; print_verdict; end
   initial begin
      step(3); rst = 0; step(1);
      chk({fifo_empty_q, roi_mode_q, mode_q, heater_on_q, seq_busy_q}, 7'h60);
      cfg(0, 8'h80, 1);
      run_seq(8'h82, 8'hC2, 2'h2);
      chk(roi_mode_q, 0);
      px(10'h064, 10'h064, 12'h0101, 1);
      px(10'h064, 10'h064, 12'h0100, 0);
      px(10'h3FF, 10'h007, 12'h0000, 1);
      px(10'h000, 10'h3F8, 12'h0000, 1);
      px(10'h000, 10'h008, 12'h0000, 0);
      px(10'h005, 10'h009, 12'h0FFF, 1);
      $display("threshold test done");
      slow = 1; cfg(1, 8'h80, 0);
      run_seq(8'h81, 8'hC1, 2'h1);
      slow = 0; search_roi_sel = 1; cfg(1, 8'h70, 0);
      run_seq(8'h81, 8'hC0, 2'h0);
      chk(roi_mode_q, 1);
      px(10'h068, 10'h0CC, 12'h0000, 1);
      px(10'h069, 10'h0C8, 12'h0000, 0);
      px(10'h064, 10'h0C7, 12'h0000, 0);
      px(10'h300, 10'h304, 12'h0000, 1);
      px(10'h032, 10'h032, 12'h0FFF, 0);
      $display("window test done");
      pulse_mode(4'h8, 2'h1);
      search_roi_sel = 0;
      run_seq(8'h81, 8'hC0, 2'h0);
      chk(roi_mode_q, 1);
      pulse_mode(4'h4, 2'h0);
      pulse_mode(4'h2, 2'h2);
      // 86 steps of 12 columns per band; three bands put the patch on rows 9..11
      frame_start = 1; step(258); frame_start = 0;
      px(10'h000, 10'h009, 12'h0000, 1);
      px(10'h00B, 10'h00B, 12'h0000, 1);
      px(10'h00C, 10'h009, 12'h0000, 0);
      px(10'h00B, 10'h00C, 12'h0000, 0);
      pulse_mode(4'h1, 2'h0);
      $display("mode test done");
      print_verdict;
   end
endmodule // testbench
